// ===== hdl/cmb_pkg.sv
package cmb_pkg;

    // ------------------------------------------------------------
    // Buffer geometry
    // ------------------------------------------------------------
    localparam int unsigned BUF_BYTES = 13;
    localparam int unsigned IDX_W     = 4;
    localparam int unsigned NUM_TX    = 3;
    localparam int unsigned SEL_W     = 2;
    localparam int unsigned LOCAL_PRIORITY_FIELD_W    = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [NUM_TX-1:0] TXE_RST    = 3'h7;
    localparam logic [NUM_TX-1:0] ABT_RST    = 3'h0;
    localparam logic              RXF_RST    = 1'h0;
    localparam logic              TX_PIN_RST = 1'h1;
    localparam logic [7:0]        BYTE_ZERO  = 8'h00;

endpackage

// ===== hdl/cmb_local_priority_field_sel.sv
module cmb_local_priority_field_sel
    import cmb_pkg::*;
#(
    parameter int unsigned N  = NUM_TX,
    parameter int unsigned PW = LOCAL_PRIORITY_FIELD_W,
    parameter int unsigned SW = SEL_W
)
(
    input  wire logic [N-1:0]         ready_in,
    input  wire logic [N-1:0][PW-1:0] local_priority_field_in,
    output logic                      valid_out,
    output logic      [SW-1:0]        idx_out
);

    // ------------------------------------------------------------
    // Smallest value wins; strict compare keeps the lowest index.
    // ------------------------------------------------------------
    always_comb
    begin
        logic [PW-1:0] best;
        best      = '1;
        valid_out = 1'b0;
        idx_out   = '0;
        for (int i = 0; i < N; i++)
        begin
            if (ready_in[i] && (!valid_out || local_priority_field_in[i] < best))
            begin
                valid_out = 1'b1;
                best      = local_priority_field_in[i];
                idx_out   = SW'(i);
            end
        end
    end

endmodule

// ===== hdl/cmb_message_buffers.sv
module cmb_message_buffers
    import cmb_pkg::*;
(
    input  wire logic                     CLK_SYS_IN,
    input  wire logic                     SYS_RST_IN,
    input  wire logic                     CLK_EN_IN,
    input  wire logic                     CAN_RECEIVE_PIN_IN,
    input  wire logic                     TX_DOMINANT_IN,
    output logic                          CAN_TRANSMIT_PIN_OUT,
    output logic                          RX_BIT_OUT,
    input  wire logic                     LOOPBACK_IN,
    input  wire logic                     RX_BYTE_VALID_IN,
    input  wire logic [IDX_W-1:0]         RX_BYTE_IDX_IN,
    input  wire logic [7:0]               RX_BYTE_IN,
    input  wire logic                     RX_FRAME_OK_IN,
    input  wire logic                     RX_ID_HIT_IN,
    input  wire logic                     RX_OWN_FRAME_IN,
    output logic                          ACK_ALLOW_OUT,
    input  wire logic [IDX_W-1:0]         FG_RD_IDX_IN,
    output logic [7:0]                    FG_RD_DATA_OUT,
    input  wire logic                     RXF_CLEAR_IN,
    output logic                          RX_FULL_FLAG_OUT,
    input  wire logic                     RX_IRQ_EN_IN,
    output logic                          RX_IRQ_OUT,
    input  wire logic                     OVR_CLEAR_IN,
    output logic                          OVR_FLAG_OUT,
    input  wire logic                     OVR_IRQ_EN_IN,
    output logic                          OVR_IRQ_OUT,
    input  wire logic                     TX_WR_IN,
    input  wire logic [SEL_W-1:0]         TX_WR_BUF_IN,
    input  wire logic [IDX_W-1:0]         TX_WR_IDX_IN,
    input  wire logic [7:0]               TX_WR_DATA_IN,
    input  wire logic                     LOCAL_PRIORITY_FIELD_WR_IN,
    input  wire logic [SEL_W-1:0]         LOCAL_PRIORITY_FIELD_WR_BUF_IN,
    input  wire logic [LOCAL_PRIORITY_FIELD_W-1:0]        LOCAL_PRIORITY_FIELD_WR_DATA_IN,
    input  wire logic [NUM_TX-1:0]        TXE_CLEAR_IN,
    output logic [NUM_TX-1:0]             TX_EMPTY_FLAG_OUT,
    input  wire logic [NUM_TX-1:0]        ABORT_REQ_SET_IN,
    output logic [NUM_TX-1:0]             ABORT_REQUEST_FLAG_OUT,
    output logic [NUM_TX-1:0]             ABORT_ACKNOWLEDGE_FLAG_OUT,
    input  wire logic [NUM_TX-1:0]        TX_IRQ_EN_IN,
    output logic                          TX_IRQ_OUT,
    input  wire logic                     ARB_START_IN,
    input  wire logic                     TX_DONE_IN,
    input  wire logic                     TX_ERROR_IN,
    input  wire logic                     ARB_LOST_IN,
    output logic                          TX_SEL_VALID_OUT,
    output logic [SEL_W-1:0]              TX_SEL_BUF_OUT,
    input  wire logic [IDX_W-1:0]         TX_RD_IDX_IN,
    output logic [7:0]                    TX_RD_DATA_OUT
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef logic [BUF_BYTES-1:0][7:0] cmb_frame_t;

    typedef struct packed {
        cmb_frame_t                           bg;
        cmb_frame_t                           fg;
        logic                                 rx_full_flag;
        logic                                 bg_full;
        logic                                 ovr;
        logic [NUM_TX-1:0][BUF_BYTES-1:0][7:0] tx;
        logic [NUM_TX-1:0][LOCAL_PRIORITY_FIELD_W-1:0]        local_priority_field;
        logic [NUM_TX-1:0]                    tx_empty_flag;
        logic [NUM_TX-1:0]                    abt_rq;
        logic [NUM_TX-1:0]                    abt_ak;
        logic                                 active;
        logic [SEL_W-1:0]                     sel;
        logic                                 tx_pin;
        logic                                 rx_bit;
        logic [7:0]                           fg_rd;
        logic [7:0]                           tx_rd;
    } cmb_state_t;

    cmb_state_t        r;
    cmb_state_t        n;
    logic              accept;
    logic              own_local;
    logic              pick_valid;
    logic [SEL_W-1:0]  pick_idx;

    function automatic logic idx_ok(input logic [IDX_W-1:0] i);
        return 32'(i) < BUF_BYTES;
    endfunction

    function automatic logic [7:0] byte_at(input cmb_frame_t b,
                                           input logic [IDX_W-1:0] i);
        return idx_ok(i) ? b[i] : BYTE_ZERO;
    endfunction

    // ------------------------------------------------------------
    // Transmit buffer selection
    // ------------------------------------------------------------
    cmb_local_priority_field_sel u_sel
    (
        .ready_in  (~r.tx_empty_flag & ~r.abt_rq),
        .local_priority_field_in   (r.local_priority_field),
        .valid_out (pick_valid),
        .idx_out   (pick_idx)
    );

    // Own frames count as foreign only in loop-back, or after the engine
    // has dropped them as own because arbitration was lost.
    assign own_local = RX_OWN_FRAME_IN && !LOOPBACK_IN;
    assign accept    = RX_FRAME_OK_IN && RX_ID_HIT_IN && !own_local;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        n = r;
        n.tx_pin = !TX_DOMINANT_IN;
        n.rx_bit = CAN_RECEIVE_PIN_IN;

        // Background bytes are dropped while it still holds a waiting
        // frame, which is what makes a third frame an overrun.
        if (RX_BYTE_VALID_IN && idx_ok(RX_BYTE_IDX_IN) && !r.bg_full)
        begin
            n.bg[RX_BYTE_IDX_IN] = RX_BYTE_IN;
        end

        // Release of the foreground refills it from a waiting background.
        if (RXF_CLEAR_IN && r.rx_full_flag)
        begin
            if (r.bg_full)
            begin
                n.fg      = r.bg;
                n.bg_full = 1'b0;
            end
            else
            begin
                n.rx_full_flag = 1'b0;
            end
        end
        if (OVR_CLEAR_IN)
        begin
            n.ovr = 1'b0;
        end

        if (accept)
        begin
            if (r.bg_full)
            begin
                n.ovr = 1'b1;
            end
            else if (!n.rx_full_flag)
            begin
                n.fg  = r.bg;
                n.rx_full_flag = 1'b1;
            end
            else
            begin
                n.bg_full = 1'b1;
            end
        end

        // Software side of the transmit buffers.
        if (TX_WR_IN && r.tx_empty_flag[TX_WR_BUF_IN] && idx_ok(TX_WR_IDX_IN))
        begin
            n.tx[TX_WR_BUF_IN][TX_WR_IDX_IN] = TX_WR_DATA_IN;
        end
        if (LOCAL_PRIORITY_FIELD_WR_IN && r.tx_empty_flag[LOCAL_PRIORITY_FIELD_WR_BUF_IN])
        begin
            n.local_priority_field[LOCAL_PRIORITY_FIELD_WR_BUF_IN] = LOCAL_PRIORITY_FIELD_WR_DATA_IN;
        end
        n.tx_empty_flag    = n.tx_empty_flag & ~TXE_CLEAR_IN;
        n.abt_ak = n.abt_ak & ~TXE_CLEAR_IN;
        n.abt_rq = (n.abt_rq & ~TXE_CLEAR_IN) | (ABORT_REQ_SET_IN & ~r.tx_empty_flag);

        // Engine side; full receive buffers never hold this back.
        if (r.active && (TX_ERROR_IN || ARB_LOST_IN))
        begin
            n.active = 1'b0;
        end
        if (ARB_START_IN && !r.active)
        begin
            n.active = pick_valid;
            n.sel    = pick_idx;
        end
        if (r.active && TX_DONE_IN)
        begin
            n.active        = 1'b0;
            n.tx_empty_flag[r.sel]    = 1'b1;
            n.abt_rq[r.sel] = 1'b0;
            n.abt_ak[r.sel] = 1'b0;
        end
        for (int i = 0; i < NUM_TX; i++)
        begin
            if (r.abt_rq[i] && !r.tx_empty_flag[i] &&
                !(r.active && 32'(r.sel) == i))
            begin
                n.tx_empty_flag[i]    = 1'b1;
                n.abt_ak[i] = 1'b1;
                n.abt_rq[i] = 1'b0;
            end
        end

        n.fg_rd = byte_at(r.fg, FG_RD_IDX_IN);
        n.tx_rd = byte_at(r.tx[r.sel], TX_RD_IDX_IN);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (SYS_RST_IN)
        begin
            r        <= '0;
            r.rx_full_flag    <= RXF_RST;
            r.tx_empty_flag    <= TXE_RST;
            r.abt_rq <= ABT_RST;
            r.abt_ak <= ABT_RST;
            r.tx_pin <= TX_PIN_RST;
            r.rx_bit <= TX_PIN_RST;
        end
        else if (CLK_EN_IN)
        begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign CAN_TRANSMIT_PIN_OUT       = r.tx_pin;
    assign RX_BIT_OUT                 = r.rx_bit;
    assign ACK_ALLOW_OUT              = !r.active || LOOPBACK_IN;
    assign FG_RD_DATA_OUT             = r.fg_rd;
    assign RX_FULL_FLAG_OUT           = r.rx_full_flag;
    assign RX_IRQ_OUT                 = r.rx_full_flag && RX_IRQ_EN_IN;
    assign OVR_FLAG_OUT               = r.ovr;
    assign OVR_IRQ_OUT                = r.ovr && OVR_IRQ_EN_IN;
    assign TX_EMPTY_FLAG_OUT          = r.tx_empty_flag;
    assign ABORT_REQUEST_FLAG_OUT     = r.abt_rq;
    assign ABORT_ACKNOWLEDGE_FLAG_OUT = r.abt_ak;
    assign TX_IRQ_OUT                 = |(r.tx_empty_flag & TX_IRQ_EN_IN);
    assign TX_SEL_VALID_OUT           = r.active;
    assign TX_SEL_BUF_OUT             = r.sel;
    assign TX_RD_DATA_OUT             = r.tx_rd;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_pin_level: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        CLK_EN_IN |=> CAN_TRANSMIT_PIN_OUT == !$past(TX_DOMINANT_IN))
    else $error("Transmit pin level does not follow dominant request.");

    chk_fg_copy: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        CLK_EN_IN && accept && !r.rx_full_flag && !r.bg_full
        |=> RX_FULL_FLAG_OUT && r.fg == $past(r.bg))
    else $error("Accepted frame was not copied to the foreground.");

    chk_own_no_copy: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        CLK_EN_IN && RX_FRAME_OK_IN && own_local && !r.rx_full_flag
        |=> !RX_FULL_FLAG_OUT && r.fg == $past(r.fg))
    else $error("Own frame reached the foreground buffer.");

    chk_overrun_set: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        CLK_EN_IN && accept && r.rx_full_flag && r.bg_full && !RXF_CLEAR_IN
        |=> OVR_FLAG_OUT && r.bg_full && r.fg == $past(r.fg))
    else $error("Third accepted frame did not raise overrun.");

    chk_rx_irq_gate: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        RX_IRQ_OUT |-> RX_FULL_FLAG_OUT && RX_IRQ_EN_IN)
    else $error("Receive interrupt raised without full flag or enable.");

    chk_arb_select: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        CLK_EN_IN && ARB_START_IN && !r.active && pick_valid
        |=> TX_SEL_VALID_OUT && !TX_EMPTY_FLAG_OUT[TX_SEL_BUF_OUT])
    else $error("Arbitration start did not select a ready buffer.");

    chk_lowest_local_priority_field: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        pick_valid |->
            !(!r.tx_empty_flag[0] && !r.abt_rq[0] && r.local_priority_field[0] < r.local_priority_field[pick_idx]) &&
            !(!r.tx_empty_flag[1] && !r.abt_rq[1] && r.local_priority_field[1] < r.local_priority_field[pick_idx]) &&
            !(!r.tx_empty_flag[2] && !r.abt_rq[2] && r.local_priority_field[2] < r.local_priority_field[pick_idx]))
    else $error("Selected buffer is not the smallest priority value.");

    chk_done_empty: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        CLK_EN_IN && r.active && TX_DONE_IN
        |=> TX_EMPTY_FLAG_OUT[$past(r.sel)] &&
            !ABORT_ACKNOWLEDGE_FLAG_OUT[$past(r.sel)] && !TX_SEL_VALID_OUT)
    else $error("Sent buffer not released with acknowledge low.");

    chk_abort_grant: assert property (@(posedge CLK_SYS_IN)
        disable iff (SYS_RST_IN)
        CLK_EN_IN && r.abt_rq[0] && !r.tx_empty_flag[0] && !(r.active && r.sel == 0)
        |=> TX_EMPTY_FLAG_OUT[0] && ABORT_ACKNOWLEDGE_FLAG_OUT[0])
    else $error("Idle buffer abort was not granted.");

    chk_reset_flags: assert property (@(posedge CLK_SYS_IN)
        SYS_RST_IN |=> TX_EMPTY_FLAG_OUT == TXE_RST && !RX_FULL_FLAG_OUT &&
                       ABORT_ACKNOWLEDGE_FLAG_OUT == ABT_RST)
    else $error("Flags wrong after reset.");

endmodule

// ===== tb/cmb_bus_node.sv
module cmb_bus_node
(
    input  wire logic tx_pin_in,
    input  wire logic peer_dom_in,
    output logic      bus_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Bus seen through the transceiver
    // ------------------------------------------------------------
    // Wired-AND: a dominant low from any node beats a recessive high.
    assign bus_out = tx_pin_in & ~peer_dom_in;
endmodule

// ===== tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk, rst, txd, lb, bv, ok, hit, own, rclr, rien;
    logic       oclr, oien, twr, pwr, arb, done, terr, peer;
    logic [3:0] bidx, fidx, tidx, ridx;
    logic [7:0] bdat, tdat, pdat, fdat, rdat;
    logic [1:0] tbuf, pbuf, sb;
    logic [2:0] tclr, aset, tien, emp, areq, aack;
    logic       txp, rxbit, ackal, full, rirq, ovr, oirq, tirq, sv, bus;
    logic       cen, alost;
    int         bad_count, comparisons;

    cmb_bus_node peer_node (.tx_pin_in(txp), .peer_dom_in(peer),
        .bus_out(bus));
    // Every engine input is driven so that loss and freeze can be tested.
    cmb_message_buffers uut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
        .CLK_EN_IN(cen), .CAN_RECEIVE_PIN_IN(bus), .TX_DOMINANT_IN(txd),
        .CAN_TRANSMIT_PIN_OUT(txp), .RX_BIT_OUT(rxbit), .LOOPBACK_IN(lb),
        .RX_BYTE_VALID_IN(bv), .RX_BYTE_IDX_IN(bidx), .RX_BYTE_IN(bdat),
        .RX_FRAME_OK_IN(ok), .RX_ID_HIT_IN(hit), .RX_OWN_FRAME_IN(own),
        .ACK_ALLOW_OUT(ackal), .FG_RD_IDX_IN(fidx), .FG_RD_DATA_OUT(fdat),
        .RXF_CLEAR_IN(rclr), .RX_FULL_FLAG_OUT(full), .RX_IRQ_EN_IN(rien),
        .RX_IRQ_OUT(rirq), .OVR_CLEAR_IN(oclr), .OVR_FLAG_OUT(ovr),
        .OVR_IRQ_EN_IN(oien), .OVR_IRQ_OUT(oirq), .TX_WR_IN(twr),
        .TX_WR_BUF_IN(tbuf), .TX_WR_IDX_IN(tidx), .TX_WR_DATA_IN(tdat),
        .LOCAL_PRIORITY_FIELD_WR_IN(pwr), .LOCAL_PRIORITY_FIELD_WR_BUF_IN(pbuf), .LOCAL_PRIORITY_FIELD_WR_DATA_IN(pdat),
        .TXE_CLEAR_IN(tclr), .TX_EMPTY_FLAG_OUT(emp),
        .ABORT_REQ_SET_IN(aset), .ABORT_REQUEST_FLAG_OUT(areq),
        .ABORT_ACKNOWLEDGE_FLAG_OUT(aack), .TX_IRQ_EN_IN(tien),
        .TX_IRQ_OUT(tirq), .ARB_START_IN(arb), .TX_DONE_IN(done),
        .TX_ERROR_IN(terr), .ARB_LOST_IN(alost), .TX_SEL_VALID_OUT(sv),
        .TX_SEL_BUF_OUT(sb), .TX_RD_IDX_IN(ridx), .TX_RD_DATA_OUT(rdat));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    always #5 clk = ~clk;

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bytes first, a gap cycle, then the end-of-frame strobe.
    task rx_frame(input logic [7:0] base, input logic h, input logic o);
        for (int i = 0; i < 13; i++)
        begin
            @(posedge clk);
            bv <= 1'b1;
            bidx <= 4'(i);
            bdat <= base + 8'(i);
        end
        @(posedge clk);
        bv <= 1'b0;
        @(posedge clk);
        ok <= 1'b1;
        hit <= h;
        own <= o;
        @(posedge clk);
        ok <= 1'b0;
        #1;
    endtask

    task fg(input logic [3:0] i, input logic [7:0] e);
        @(posedge clk);
        fidx <= i;
        step(1);
        chk("foreground byte", e, fdat);
    endtask

    task clr_rx;
        @(posedge clk);
        rclr <= 1'b1;
        @(posedge clk);
        rclr <= 1'b0;
        #1;
    endtask

    task pulse_tx(input logic [2:0] c, input logic [2:0] a);
        @(posedge clk);
        tclr <= c;
        aset <= a;
        @(posedge clk);
        tclr <= 3'h0;
        aset <= 3'h0;
        #1;
    endtask

    task start_arb;
        @(posedge clk);
        arb <= 1'b1;
        @(posedge clk);
        arb <= 1'b0;
        #1;
    endtask

    task wr_local_priority_field(input logic [1:0] b, input logic [7:0] p);
        @(posedge clk);
        pwr <= 1'b1;
        pbuf <= b;
        pdat <= p;
        @(posedge clk);
        pwr <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk("tx pin", 8'h01, txp);
        chk("flags", 8'h00, {full, ovr, sv});
        chk("empty", 8'h07, emp);
        chk("abort", 8'h00, {areq, aack});
        $display("test reset done");
    endtask

    task t_pin;
        @(posedge clk);
        txd <= 1'b1;
        step(1);
        chk("tx pin dominant", 8'h00, txp);
        step(1);
        chk("rx bit", 8'h00, rxbit);
        @(posedge clk);
        txd <= 1'b0;
        peer <= 1'b1;
        step(2);
        chk("pin and bus", 8'h10, {txp, 3'h0, rxbit});
        @(posedge clk);
        peer <= 1'b0;
        step(2);
        chk("rx bit idle", 8'h01, rxbit);
        $display("test pin done");
    endtask

    task t_rx;
        rien <= 1'b1;
        rx_frame(8'h30, 1'b1, 1'b0);
        chk("full and irq", 8'h11, {full, 3'h0, rirq});
        fg(4'h0, 8'h30);
        fg(4'hc, 8'h3c);
        fg(4'hd, 8'h00);
        rien <= 1'b0;
        step(1);
        chk("irq masked", 8'h10, {full, 3'h0, rirq});
        clr_rx();
        chk("full cleared", 8'h00, full);
        rx_frame(8'h50, 1'b0, 1'b0);
        chk("filter miss", 8'h00, full);
        $display("test receive done");
    endtask

    task t_ovr;
        oien <= 1'b1;
        rx_frame(8'h10, 1'b1, 1'b0);
        rx_frame(8'h20, 1'b1, 1'b0);
        chk("two held", 8'h10, {full, 3'h0, ovr});
        rx_frame(8'h40, 1'b1, 1'b0);
        chk("overrun", 8'h11, {ovr, 3'h0, oirq});
        fg(4'h0, 8'h10);
        clr_rx();
        chk("refilled", 8'h01, full);
        fg(4'h0, 8'h20);
        clr_rx();
        chk("empty fifo", 8'h00, full);
        @(posedge clk);
        oclr <= 1'b1;
        @(posedge clk);
        oclr <= 1'b0;
        step(1);
        chk("overrun clear", 8'h00, ovr);
        $display("test overrun done");
    endtask

    task t_own;
        rx_frame(8'h70, 1'b1, 1'b1);
        chk("own frame", 8'h00, full);
        lb <= 1'b1;
        rx_frame(8'h71, 1'b1, 1'b1);
        chk("loop-back", 8'h01, full);
        fg(4'h0, 8'h71);
        clr_rx();
        lb <= 1'b0;
        $display("test own frame done");
    endtask

    task t_tx;
        tien <= 3'h2;
        wr_local_priority_field(2'h0, 8'h20);
        wr_local_priority_field(2'h1, 8'h10);
        wr_local_priority_field(2'h2, 8'h10);
        @(posedge clk);
        twr <= 1'b1;
        tbuf <= 2'h0;
        tidx <= 4'h0;
        tdat <= 8'ha5;
        @(posedge clk);
        twr <= 1'b0;
        pulse_tx(3'h1, 3'h0);
        chk("empty after load", 8'h06, emp);
        start_arb();
        chk("first pick", 8'h10, {sv, 2'h0, sb});
        chk("no self ack", 8'h00, ackal);
        @(posedge clk);
        ridx <= 4'h0;
        step(1);
        chk("tx byte", 8'ha5, rdat);
        pulse_tx(3'h6, 3'h1);
        chk("active abort", 8'h00, {aack, 1'b0, tirq});
        @(posedge clk);
        terr <= 1'b1;
        @(posedge clk);
        terr <= 1'b0;
        step(3);
        chk("error abort", 8'h11, {emp, 1'b0, aack});
        start_arb();
        chk("retry pick", 8'h11, {sv, 2'h0, sb});
        pulse_tx(3'h0, 3'h2);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        step(2);
        chk("sent", 8'h31, {emp, 1'b0, aack});
        chk("tx irq", 8'h01, {sv, 3'h0, tirq});
        pulse_tx(3'h0, 3'h4);
        step(1);
        chk("idle abort", 8'h75, {emp, 1'b0, aack});
        $display("test transmit done");
    endtask

    task t_lost;
        wr_local_priority_field(2'h0, 8'h05);
        pulse_tx(3'h1, 3'h0);
        start_arb();
        lb <= 1'b1;
        step(1);
        chk("loop-back ack", 8'h01, ackal);
        lb <= 1'b0;
        @(posedge clk);
        alost <= 1'b1;
        @(posedge clk);
        alost <= 1'b0;
        #1;
        chk("lost", 8'h06, {sv, 1'b0, emp});
        rx_frame(8'h60, 1'b1, 1'b0);
        chk("winner kept", 8'h01, full);
        fg(4'h0, 8'h60);
        clr_rx();
        start_arb();
        chk("lost retry", 8'h10, {sv, 2'h0, sb});
        @(posedge clk);
        cen <= 1'b0;
        txd <= 1'b1;
        done <= 1'b1;
        step(2);
        chk("frozen pin", 8'h01, txp);
        chk("frozen sel", 8'h16, {sv, 1'b0, emp});
        @(posedge clk);
        cen <= 1'b1;
        txd <= 1'b0;
        done <= 1'b0;
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        step(1);
        chk("sent after freeze", 8'h07, {sv, 1'b0, emp});
        $display("test lost arbitration done");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // A run needs well under 2000 cycles; this margin catches a hang.
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {txd, lb, bv, ok, hit, own, rclr, rien, oclr, oien} = '0;
        {twr, pwr, arb, done, terr, peer, bidx, fidx, tidx, ridx} = '0;
        {bdat, tdat, pdat, tbuf, pbuf, tclr, aset, tien} = '0;
        cen = 1'b1;
        alost = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        step(1);
        t_reset();
        t_pin();
        t_rx();
        t_ovr();
        t_own();
        t_tx();
        t_lost();
        tally_and_finish();
    end
endmodule
